// ---- hw/cm_pkg.sv ----
package cm_pkg;
   localparam int        CM_GROUPS  = 10;
   localparam int        CM_SLOTS   = 24;
   localparam int        CM_ADDR_W  = 7;
   // each six-byte group takes two words: bytes 3..0, then bytes 5..4
   localparam logic [6:0] CM_OFS_CFG_A  = 7'h00;
   localparam logic [6:0] CM_OFS_CFG_B  = 7'h08;
   localparam logic [6:0] CM_OFS_CVA    = 7'h10;
   localparam logic [6:0] CM_OFS_CVB    = 7'h18;
   localparam logic [6:0] CM_OFS_CVC    = 7'h20;
   localparam logic [6:0] CM_OFS_CVD    = 7'h28;
   localparam logic [6:0] CM_OFS_CVE    = 7'h30;
   localparam logic [6:0] CM_OFS_AVA    = 7'h38;
   localparam logic [6:0] CM_OFS_AVB    = 7'h40;
   localparam logic [6:0] CM_OFS_AVC    = 7'h48;
   localparam logic [6:0] CM_OFS_STATUS = 7'h50;
   localparam logic [3:0] CM_GRP_CFG_A  = 4'h0;
   localparam logic [3:0] CM_GRP_CFG_B  = 4'h1;
   localparam logic [3:0] CM_GRP_RES0   = 4'h2;
   // reset values and write masks
   localparam logic [47:0] CM_CFG_A_RESET = 48'h0000_0000_0000;
   localparam logic [47:0] CM_CFG_B_RESET = 48'h0000_0000_0000;
   localparam logic [47:0] CM_CFG_B_WMASK = 48'h0000_0000_fc7f;
   localparam logic [15:0] CM_RESULT_RESET = 16'hffff;
   // config A field positions in the 48-bit group image
   localparam int CM_A_CONV_OPT  = 0;
   localparam int CM_A_TMR_EN    = 1;
   localparam int CM_A_REF_KEEP  = 2;
   localparam int CM_A_GPIO      = 3;
   localparam int CM_A_UV        = 8;
   localparam int CM_A_OV        = 20;
   localparam int CM_A_DIS_LO    = 32;
   localparam int CM_A_DIS_HI    = 40;
   localparam int CM_A_DIS_TMO   = 44;
   // config B field positions
   localparam int CM_B_GPIO      = 0;
   localparam int CM_B_DIS       = 4;
   localparam int CM_B_DIS0      = 10;
   localparam int CM_B_TMR_MON   = 11;
   localparam int CM_B_PATH      = 12;
   localparam int CM_B_FORCE_FLT = 14;
   localparam int CM_B_MUTE      = 15;
   // overlap destination slots (slot = 3 * result group + position)
   localparam logic [4:0] CM_SLOT_C6_ADC2  = 5'h06;
   localparam logic [4:0] CM_SLOT_C6_ADC1  = 5'h07;
   localparam logic [4:0] CM_SLOT_C11_ADC3 = 5'h0c;
   localparam logic [4:0] CM_SLOT_C11_ADC2 = 5'h0d;
   localparam int         CM_STAT_OVERLAP  = 0;
   localparam logic [1:0] CM_RESP_OKAY     = 2'b00;
   localparam logic [1:0] CM_RESP_DECERR   = 2'b11;

   typedef struct packed {
      logic       valid;
      logic [4:0] slot;
      logic [15:0] value;
   } cm_result_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] cell6_adc2;
      logic [15:0] cell6_adc1;
      logic [15:0] cell11_adc3;
      logic [15:0] cell11_adc2;
   } cm_overlap_t;

   typedef struct packed {
      logic [8:0]  gpio_pin_control;
      logic        reference_keep_on;
      logic        discharge_timer_enable;
      logic        conversion_option;
      logic [11:0] undervoltage_threshold;
      logic [11:0] overvoltage_threshold;
      logic [15:0] cell_discharge_control;
      logic [3:0]  discharge_timeout;
      logic        discharge_mute;
      logic        forced_redundancy_fault;
      logic [1:0]  path_select;
      logic        timer_monitor_enable;
   } cm_config_t;
endpackage : cm_pkg

// ---- hw/cm_register_map.sv ----
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module cm_register_map
   import cm_pkg::*;
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   // axi4-lite write address and data
   input  wire logic [CM_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read
   input  wire logic [CM_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // conversion results from the converters
   input  wire cm_result_t           result_in,
   input  wire cm_overlap_t          overlap_in,
   // decoded configuration to the analog side
   output cm_config_t                config_out
);

   // byte-lane merge of a bus word into a stored word
   function automatic logic [31:0] cm_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction : cm_merge

   // write one word of a six-byte group image; byte order 0 to 5
   function automatic logic [47:0] cm_group_write(input logic [47:0] old_g,
                                                  input logic        hi_word,
                                                  input logic [31:0] data,
                                                  input logic [3:0]  strb);
      logic [47:0] res;
      logic [31:0] hi;
      res = old_g;
      hi  = cm_merge({16'h0000, old_g[47:32]}, data, {2'b00, strb[1:0]});
      if (hi_word) begin
         res[47:32] = hi[15:0];
      end else begin
         res[31:0] = cm_merge(old_g[31:0], data, strb);
      end
      return res;
   endfunction : cm_group_write

   // aligned address inside a group word, or the status word
   function automatic logic cm_mapped(input logic [CM_ADDR_W-1:0] addr);
      return (addr[1:0] == 2'b00)
             && ((addr[6:3] < 4'(CM_GROUPS)) || (addr == CM_OFS_STATUS));
   endfunction : cm_mapped

   // storage
   logic [47:0] cfg_a;
   logic [47:0] cfg_b;
   logic [15:0] result      [CM_SLOTS];
   logic [15:0] next_result [CM_SLOTS];
   logic        overlap_flag;
   logic [47:0] grp_img     [CM_GROUPS];

   // write channel holding state
   logic                 aw_held;
   logic                 w_held;
   logic [CM_ADDR_W-1:0] aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;

   // write handshake; both channels may arrive in either order
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   // a write fires once both halves are present and no response waits
   wire                 have_aw = aw_held || aw_take;
   wire                 have_w  = w_held || w_take;
   wire                 wr_fire = have_aw && have_w && !s_axi_bvalid;
   wire [CM_ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0]          wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0]           wr_strb = w_held ? w_strb : s_axi_wstrb;

   // write decode
   wire       wr_ok     = cm_mapped(wr_addr);
   wire [3:0] wr_grp    = wr_addr[6:3];
   wire       wr_hi     = wr_addr[2];
   wire       wr_cfg_a  = wr_fire && wr_ok && (wr_grp == CM_GRP_CFG_A);
   wire       wr_cfg_b  = wr_fire && wr_ok && (wr_grp == CM_GRP_CFG_B);
   wire       wr_status = wr_fire && wr_ok && (wr_addr == CM_OFS_STATUS);
   // result group writes match none of the strobes above and are dropped
   // with an okay answer, so a host sweeping the map is not faulted

   wire [47:0] next_cfg_a = cm_group_write(cfg_a, wr_hi, wr_data, wr_strb);
   wire [47:0] cfg_b_raw  = cm_group_write(cfg_b, wr_hi, wr_data, wr_strb);
   // reserved config B bits never store, so they read as zero
   wire [47:0] next_cfg_b = cfg_b_raw & CM_CFG_B_WMASK;

   // write channel capture
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (aw_take) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (w_take) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
   end

   // write response, one cycle after the write fires
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= CM_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? CM_RESP_OKAY : CM_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // configuration groups
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_a <= CM_CFG_A_RESET;
         cfg_b <= CM_CFG_B_RESET;
      end else begin
         if (wr_cfg_a) cfg_a <= next_cfg_a;
         if (wr_cfg_b) cfg_b <= next_cfg_b;
      end
   end

   // overlap marker: set wins over a software clear in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overlap_flag <= 1'b0;
      end else if (overlap_in.valid) begin
         overlap_flag <= 1'b1;
      end else if (wr_status && wr_strb[0] && wr_data[CM_STAT_OVERLAP]) begin
         overlap_flag <= 1'b0;
      end
   end

   // result slot update; the overlap layout overrides a plain result
   // landing on the same slot, since both cannot be current at once
   always_comb begin
      for (int i = 0; i < CM_SLOTS; i++) begin
         next_result[i] = result[i];
         if (result_in.valid && (result_in.slot == 5'(i))) begin
            next_result[i] = result_in.value;
         end
      end
      if (overlap_in.valid) begin
         next_result[CM_SLOT_C6_ADC2]  = overlap_in.cell6_adc2;
         next_result[CM_SLOT_C6_ADC1]  = overlap_in.cell6_adc1;
         next_result[CM_SLOT_C11_ADC3] = overlap_in.cell11_adc3;
         next_result[CM_SLOT_C11_ADC2] = overlap_in.cell11_adc2;
      end
   end

   // result storage, written only from the converter side
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CM_SLOTS; i++) result[i] <= CM_RESULT_RESET;
      end else begin
         for (int i = 0; i < CM_SLOTS; i++) result[i] <= next_result[i];
      end
   end

   // group images, low byte of each result first
   always_comb begin
      grp_img[0] = cfg_a;
      grp_img[1] = cfg_b;
      for (int g = 0; g < CM_GROUPS - 2; g++) begin
         grp_img[g+2] = {result[3*g+2], result[3*g+1], result[3*g]};
      end
   end

   // read decode
   wire       ar_take  = s_axi_arvalid && s_axi_arready;
   wire       rd_ok    = cm_mapped(s_axi_araddr);
   wire [3:0] rd_grp   = s_axi_araddr[6:3];
   wire       rd_hi    = s_axi_araddr[2];
   wire       rd_stat  = (s_axi_araddr == CM_OFS_STATUS);
   wire [47:0] rd_img  = (rd_grp < 4'(CM_GROUPS)) ? grp_img[rd_grp] : 48'h0;
   wire [31:0] rd_word = !rd_ok ? 32'h0000_0000
                       : rd_stat ? {31'h0000_0000, overlap_flag}
                       : rd_hi ? {16'h0000, rd_img[47:32]}
                       : rd_img[31:0];
   assign s_axi_arready = !s_axi_rvalid;

   // read data channel
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= CM_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? CM_RESP_OKAY : CM_RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // configuration fields straight from the group flops
   assign config_out.gpio_pin_control[4:0]   = cfg_a[CM_A_GPIO +: 5];
   assign config_out.reference_keep_on       = cfg_a[CM_A_REF_KEEP];
   assign config_out.discharge_timer_enable  = cfg_a[CM_A_TMR_EN];
   assign config_out.conversion_option       = cfg_a[CM_A_CONV_OPT];
   assign config_out.undervoltage_threshold  = cfg_a[CM_A_UV +: 12];
   assign config_out.overvoltage_threshold   = cfg_a[CM_A_OV +: 12];
   assign config_out.cell_discharge_control[8:1]  = cfg_a[CM_A_DIS_LO +: 8];
   assign config_out.cell_discharge_control[12:9] = cfg_a[CM_A_DIS_HI +: 4];
   assign config_out.discharge_timeout       = cfg_a[CM_A_DIS_TMO +: 4];
   assign config_out.gpio_pin_control[8:5]   = cfg_b[CM_B_GPIO +: 4];
   assign config_out.cell_discharge_control[15:13] = cfg_b[CM_B_DIS +: 3];
   assign config_out.cell_discharge_control[0] = cfg_b[CM_B_DIS0];
   assign config_out.timer_monitor_enable    = cfg_b[CM_B_TMR_MON];
   assign config_out.path_select             = cfg_b[CM_B_PATH +: 2];
   assign config_out.forced_redundancy_fault = cfg_b[CM_B_FORCE_FLT];
   assign config_out.discharge_mute          = cfg_b[CM_B_MUTE];

endmodule : cm_register_map

// ---- verif/cm_conv_model.sv ----
`timescale 1ns/1ps
module cm_conv_model
   import cm_pkg::*;
(
   // clock and reset
   input  wire logic  clock,
   input  wire logic  rst_n,
   // requests from the bench
   input  wire logic  stream_go,
   input  wire logic  overlap_go,
   // converter outputs
   output cm_result_t  result_in,
   output cm_overlap_t overlap_in
);
   logic [4:0] idx;
   logic       run;

   // one result per cycle, slots 0 to 23, then silent
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run <= 1'b0;
         idx <= 5'h00;
      end else if (stream_go) begin
         run <= 1'b1;
         idx <= 5'h00;
      end else if (run) begin
         idx <= idx + 5'h01;
         run <= (idx != 5'h17);
      end
   end

   // value carries its own slot so a misplaced result shows
   assign result_in = {run, idx, 8'ha5, 3'h0, idx};
   // fixed overlap values, distinct per converter
   assign overlap_in = {overlap_go, 16'h6002, 16'h6001, 16'hb003, 16'hb002};
endmodule : cm_conv_model

// ---- verif/cm_register_map_chk.sv ----
`timescale 1ns/1ps
module cm_register_map_chk
   import cm_pkg::*;
(
   // clock and reset
   input wire logic                 clock,
   input wire logic                 rst_n,
   // bus
   input wire logic [CM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic [31:0]          s_axi_wdata,
   input wire logic [3:0]           s_axi_wstrb,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic [CM_ADDR_W-1:0] s_axi_araddr,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic [1:0]           s_axi_rresp,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   // converter side and decoded fields
   input wire cm_result_t           result_in,
   input wire cm_overlap_t          overlap_in,
   input wire cm_config_t           config_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [31:0] wd_q;

   // last write data, kept for the field comparison one cycle on
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) wd_q <= 32'h0;
      else wd_q <= s_axi_wdata;
   end

   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_write_resp: assert property (s_wr |=> s_axi_bvalid)
      else $error("write got no response");
   a_read_resp: assert property (s_rd |=> s_axi_rvalid)
      else $error("read got no response");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_unaligned_err: assert property (s_rd ##0 (s_axi_araddr[1:0] != 2'b00)
      |=> s_axi_rresp == CM_RESP_DECERR && s_axi_rdata == 32'h0)
      else $error("unaligned read not refused");
   a_high_zero: assert property (s_rd ##0 (s_axi_araddr[2:0] == 3'h4)
      |=> s_axi_rdata[31:16] == 16'h0)
      else $error("upper half of high word not zero");
   a_cfga_thresh: assert property (s_wr ##0 (s_axi_awaddr == 7'h00 && s_axi_wstrb == 4'hf)
      |=> {config_out.overvoltage_threshold, config_out.undervoltage_threshold} == wd_q[31:8])
      else $error("threshold fields do not follow write");
   a_cfgb_rsvd: assert property (s_rd ##0 (s_axi_araddr == 7'h08)
      |=> (s_axi_rdata & 32'hffff_0380) == 32'h0)
      else $error("reserved config b bits read nonzero");
endmodule : cm_register_map_chk

bind cm_register_map cm_register_map_chk u_cm_register_map_chk (.*);

// ---- verif/cm_register_map_tb.sv ----
`timescale 1ns/1ps
module cm_register_map_tb
   import cm_pkg::*;
;
   logic [CM_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]          s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]           s_axi_wstrb = '0;
   logic [1:0]           s_axi_bresp, s_axi_rresp;
   logic                 clock = 0, rst_n = 0, stream_go = 0, overlap_go = 0;
   logic                 s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic                 s_axi_arvalid = 0, s_axi_rready = 0;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   cm_result_t           result_in;
   cm_overlap_t          overlap_in;
   cm_config_t           config_out, c;
   int                   err_count = 0, n_checks = 0;

   assign c = config_out;
   always #2 clock = ~clock;
   cm_register_map u_cm_register_map (.*);
   cm_conv_model u_cm_conv_model (.*);

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask : chk

   // write with both channels offered together, bready held until response
   task automatic wc(input logic [6:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      int n;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) err_count++;
      if (n == 50) complete_run();
      chk(s_axi_bresp, er);
   endtask : wc

   // read and compare data and response
   task automatic rc(input logic [6:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) err_count++;
      if (n == 50) complete_run();
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
   endtask : rc

   // value the converter model sends for a slot
   function automatic logic [15:0] cv(input int x);
      return {8'ha5, 3'h0, x[4:0]};
   endfunction : cv

   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      rc(7'h00, 32'h0, CM_RESP_OKAY);
      rc(7'h4c, 32'h0000_ffff, CM_RESP_OKAY);
      $display("test reset done");
      // upper half of the high word must be dropped
      wc(7'h00, 32'h9abc_d5f7, 4'hf, CM_RESP_OKAY);
      wc(7'h04, 32'hffff_a5c3, 4'hf, CM_RESP_OKAY);
      rc(7'h04, 32'h0000_a5c3, CM_RESP_OKAY);
      chk({c.gpio_pin_control[4:0], c.reference_keep_on}, 32'h3d);
      chk({c.discharge_timer_enable, c.conversion_option}, 32'h3);
      chk({c.undervoltage_threshold, c.overvoltage_threshold}, 32'hcd59ab);
      chk({c.cell_discharge_control[12:1], c.discharge_timeout}, 32'h5c3a);
      wc(7'h00, 32'h0, 4'h1, CM_RESP_OKAY);
      rc(7'h00, 32'h9abc_d500, CM_RESP_OKAY);
      $display("test config a done");
      // reserved bits set on purpose
      wc(7'h08, 32'hff00_96b5, 4'hf, CM_RESP_OKAY);
      rc(7'h08, 32'h0000_9435, CM_RESP_OKAY);
      chk({c.gpio_pin_control[8:5], c.cell_discharge_control[15:13]}, 32'h2b);
      chk({c.discharge_mute, c.forced_redundancy_fault, c.path_select}, 32'h9);
      chk({c.timer_monitor_enable, c.cell_discharge_control[0]}, 32'h1);
      wc(7'h0c, 32'hffff_ffff, 4'hf, CM_RESP_OKAY);
      rc(7'h0c, 32'h0, CM_RESP_OKAY);
      $display("test config b done");
      // model streams 24 results back to back
      stream_go <= 1'b1;
      @(posedge clock);
      stream_go <= 1'b0;
      repeat (26) @(posedge clock);
      for (int g = 0; g < 8; g++) begin
         rc(CM_OFS_CVA + 7'(8 * g), {cv(3 * g + 1), cv(3 * g)}, CM_RESP_OKAY);
         rc(CM_OFS_CVA + 7'(8 * g + 4), {16'h0, cv(3 * g + 2)}, CM_RESP_OKAY);
      end
      $display("test results done");
      wc(7'h10, 32'h0, 4'hf, CM_RESP_OKAY);
      rc(7'h10, {cv(1), cv(0)}, CM_RESP_OKAY);
      wc(7'h02, 32'h1, 4'hf, CM_RESP_DECERR);
      rc(7'h00, 32'h9abc_d500, CM_RESP_OKAY);
      rc(7'h03, 32'h0, CM_RESP_DECERR);
      rc(7'h54, 32'h0, CM_RESP_DECERR);
      $display("test refusals done");
      overlap_go <= 1'b1;
      @(posedge clock);
      overlap_go <= 1'b0;
      rc(7'h20, 32'h6001_6002, CM_RESP_OKAY);
      rc(7'h24, {16'h0, cv(8)}, CM_RESP_OKAY);
      rc(7'h30, 32'hb002_b003, CM_RESP_OKAY);
      rc(7'h34, {16'h0, cv(14)}, CM_RESP_OKAY);
      // overlap marker set, then cleared by writing one
      rc(CM_OFS_STATUS, 32'h1, CM_RESP_OKAY);
      wc(CM_OFS_STATUS, 32'h1, 4'h1, CM_RESP_OKAY);
      rc(CM_OFS_STATUS, 32'h0, CM_RESP_OKAY);
      $display("test overlap done");
      complete_run();
   end
endmodule : cm_register_map_tb
